// file: hw/crp_pkg.sv
// Package for the card read punch controller: codes, status layout, carriers.
// Assumes a single 100 MHz clock domain and one user of these types.
package crp_pkg;
  localparam logic [2:0] CMD_MAINT   = 3'h0;
  localparam logic [2:0] CMD_CONTROL = 3'h4;
  localparam logic [2:0] CMD_PUNCH   = 3'h5;
  localparam logic [2:0] CMD_READ    = 3'h6;
  localparam logic [2:0] CMD_SENSE   = 3'h7;
  localparam int MOD_PACKED  = 15;
  localparam int MOD_RESET   = 15;
  localparam int MOD_FEED    = 14;
  localparam int PUNCH_LAST  = 12;
  localparam logic [6:0] LAST_COLUMN = 7'h50;
  localparam logic [6:0] FIRST_COLUMN = 7'h01;
  localparam logic [5:0] PACKED_WORDS = 6'h28;
  localparam logic [15:0] IPL_BASE = 16'h0000;
  localparam logic [1:0] EXTRA_FEEDS = 2'h2;
  // Status word bit positions
  localparam int ST_NOT_READY   = 0;
  localparam int ST_BUSY        = 1;
  localparam int ST_LAST_CARD   = 2;
  localparam int ST_PARITY      = 3;
  localparam int ST_PROTECT     = 4;
  localparam int ST_ANY_ERROR   = 5;
  localparam int ST_MAINT       = 6;
  localparam int ST_HOPPER_ERR  = 7;

  typedef struct packed {
    logic [2:0]  code;
    logic [15:0] modifier;
  } crp_cmd_t;

  typedef struct packed {
    logic power_on;
    logic card_at_read;
    logic hopper_loaded;
    logic stacker_full;
    logic check_light;
    logic chip_box_ok;
    logic start_key;
    logic stop_key;
    logic runout_key;
    logic host_running;
  } crp_panel_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_FEED  = 4'h2,
    ST_READ  = 4'h4,
    ST_PUN   = 4'h8
  } crp_state_t;
endpackage

// file: hw/crp_fifo.sv
// Parameterised valid/ready FIFO for column data words.
// Assumes one clock; both sides may stall.
`timescale 1ns/10ps
module crp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem[rd_ptr_reg];

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// file: hw/crp_ctrl.sv
// Card read punch controller: command decode, feed/read/punch sequencing, status.
// Assumes panel sensors synchronised here; host channel logic on the same clock.
`timescale 1ns/10ps
module crp_ctrl #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_n_i,
  // Host command port
  input  wire logic                 cmd_valid_i,
  input  wire crp_pkg::crp_cmd_t    cmd_i,
  input  wire logic                 ipl_i,
  output logic                      cmd_accept_o,
  output logic                      cmd_refused_o,
  output logic [15:0]               status_word_o,
  output logic                      status_valid_o,
  output logic                      op_complete_o,
  // Cycle steal: read data to host
  output logic                      steal_rd_valid_o,
  output logic [15:0]               steal_rd_data_o,
  output logic [15:0]               steal_rd_addr_o,
  input  wire logic                 steal_rd_ready_i,
  // Cycle steal: punch data from host
  output logic                      steal_wr_req_o,
  input  wire logic                 steal_wr_valid_i,
  input  wire logic [15:0]          steal_wr_data_i,
  // Channel error reports
  input  wire logic                 parity_err_i,
  input  wire logic                 protect_err_i,
  // Mechanism
  input  wire crp_pkg::crp_panel_t  panel_i,
  input  wire logic [11:0]          column_data_i,
  input  wire logic                 column_check_ok_i,
  input  wire logic                 punch_check_ok_i,
  input  wire logic                 feed_done_i,
  input  wire logic                 hopper_err_i,
  output logic                      feed_drive_o,
  output logic                      punch_step_o,
  output logic [11:0]               punch_data_o,
  output logic                      meter_run_o,
  output logic                      ready_o
);
  typedef struct packed {
    crp_pkg::crp_state_t state;
    logic        busy;
    logic        maint;
    logic        packed_mode;
    logic        do_read;
    logic        pending_punch;
    logic        card_punched;
    logic        card_at_punch;
    logic        stopped;
    logic        hopper_dropped;
    logic [1:0]  extra_left;
    logic        last_card;
    logic        parity;
    logic        protect;
    logic        hopper_err;
    logic [6:0]  column;
    logic [7:0]  odd_half;
    logic [15:0] addr;
    logic        wait_punch;
    logic        accept;
    logic        refused;
    logic [15:0] status;
    logic        status_valid;
    logic        complete;
    logic        feed_drive;
    logic        punch_step;
    logic [11:0] punch_data;
    logic        steal_req;
    logic        meter;
    logic        ready;
  } crp_ctrl_st_t;

  crp_ctrl_st_t st_reg;
  crp_ctrl_st_t st_next;
  crp_pkg::crp_panel_t panel_meta_reg;
  crp_pkg::crp_panel_t panel_sync_reg;
  logic        start_seen_reg;
  logic        start_rise;
  logic        can_ready;
  logic        fifo_in_ready;
  logic        fifo_push;
  logic [15:0] fifo_word;

  // Panel inputs are mechanical and asynchronous
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      panel_meta_reg <= '0;
      panel_sync_reg <= '0;
      start_seen_reg <= 1'b0;
    end else begin
      panel_meta_reg <= panel_i;
      panel_sync_reg <= panel_meta_reg;
      start_seen_reg <= panel_sync_reg.start_key;
    end
  end
  assign start_rise = panel_sync_reg.start_key && !start_seen_reg;

  // Base ready conditions; hopper may be replaced by an active last-card run
  assign can_ready = panel_sync_reg.power_on && panel_sync_reg.card_at_read &&
                     (panel_sync_reg.hopper_loaded || st_reg.extra_left != 2'h0) &&
                     !panel_sync_reg.stacker_full && !panel_sync_reg.check_light &&
                     !st_reg.stopped && !st_reg.hopper_dropped &&
                     panel_sync_reg.chip_box_ok;

  always_comb begin
    logic [2:0] code;
    logic [15:0] md;
    st_next = st_reg;
    code = cmd_i.code;
    md = cmd_i.modifier;
    fifo_push = 1'b0;
    fifo_word = '0;
    st_next.accept = 1'b0;
    st_next.refused = 1'b0;
    st_next.status_valid = 1'b0;
    st_next.complete = 1'b0;
    st_next.punch_step = 1'b0;
    st_next.steal_req = 1'b0;
    if (panel_sync_reg.stop_key) begin
      st_next.stopped = 1'b1;
    end
    if (start_rise) begin
      st_next.stopped = 1'b0;
      st_next.hopper_dropped = 1'b0;
      // Empty hopper with card at read: last-card run
      if (!panel_sync_reg.hopper_loaded && panel_sync_reg.card_at_read) begin
        st_next.extra_left = crp_pkg::EXTRA_FEEDS;
      end else if (panel_sync_reg.power_on && panel_sync_reg.hopper_loaded &&
                   !panel_sync_reg.card_at_read && st_reg.state == crp_pkg::ST_IDLE) begin
        st_next.state = crp_pkg::ST_FEED;
        st_next.busy = 1'b1;
        st_next.feed_drive = 1'b1;
        st_next.do_read = 1'b0;
        st_next.pending_punch = 1'b0;
      end
    end
    if (parity_err_i) begin
      st_next.parity = 1'b1;
    end
    if (protect_err_i) begin
      st_next.protect = 1'b1;
    end
    if (cmd_valid_i) begin
      if (code == crp_pkg::CMD_SENSE) begin
        st_next.status_valid = 1'b1;
        st_next.accept = 1'b1;
        if (md[crp_pkg::MOD_RESET]) begin
          // Set wins over clear
          st_next.parity = parity_err_i;
          st_next.protect = protect_err_i;
          st_next.hopper_err = 1'b0;
        end
      end else if (st_reg.busy || !st_reg.ready) begin
        st_next.refused = 1'b1;
      end else begin
        st_next.accept = 1'b1;
        st_next.column = crp_pkg::FIRST_COLUMN;
        st_next.meter = 1'b1;
        unique case (code)
          crp_pkg::CMD_READ: begin
            st_next.state = crp_pkg::ST_FEED;
            st_next.busy = 1'b1;
            st_next.feed_drive = 1'b1;
            st_next.do_read = 1'b1;
            st_next.packed_mode = md[crp_pkg::MOD_PACKED] || ipl_i;
            st_next.addr = ipl_i ? crp_pkg::IPL_BASE : md;
          end
          crp_pkg::CMD_PUNCH: begin
            st_next.busy = 1'b1;
            st_next.addr = md;
            if (!st_reg.card_at_punch || st_reg.card_punched) begin
              st_next.state = crp_pkg::ST_FEED;
              st_next.feed_drive = 1'b1;
              st_next.do_read = 1'b0;
              st_next.pending_punch = 1'b1;
            end else begin
              st_next.state = crp_pkg::ST_PUN;
              st_next.steal_req = 1'b1;
            end
          end
          crp_pkg::CMD_CONTROL: begin
            if (md[crp_pkg::MOD_FEED]) begin
              st_next.state = crp_pkg::ST_FEED;
              st_next.busy = 1'b1;
              st_next.feed_drive = 1'b1;
              st_next.do_read = 1'b0;
              st_next.pending_punch = 1'b0;
            end else begin
              st_next.meter = 1'b0;
            end
          end
          crp_pkg::CMD_MAINT: begin
            st_next.maint = md[crp_pkg::MOD_RESET];
          end
          default: begin
            st_next.refused = 1'b1;
          end
        endcase
      end
    end
    unique case (st_reg.state)
      crp_pkg::ST_IDLE: begin
      end
      crp_pkg::ST_FEED: begin
        if (hopper_err_i) begin
          // Abort: no read, no punch, card in hopper stays
          st_next.state = crp_pkg::ST_IDLE;
          st_next.feed_drive = 1'b0;
          st_next.busy = 1'b0;
          st_next.hopper_err = 1'b1;
          st_next.pending_punch = 1'b0;
        end else if (feed_done_i) begin
          st_next.feed_drive = 1'b0;
          st_next.card_at_punch = panel_sync_reg.card_at_read;
          st_next.card_punched = 1'b0;
          if (!panel_sync_reg.hopper_loaded && st_reg.extra_left == 2'h0) begin
            st_next.hopper_dropped = 1'b1;
          end
          if (st_reg.extra_left != 2'h0) begin
            st_next.extra_left = st_reg.extra_left - 2'h1;
            st_next.last_card = (st_reg.extra_left == crp_pkg::EXTRA_FEEDS);
            if (st_reg.extra_left == 2'h1) begin
              st_next.meter = 1'b0;
            end
          end
          if (st_reg.do_read) begin
            st_next.state = crp_pkg::ST_READ;
          end else if (st_reg.pending_punch) begin
            st_next.state = crp_pkg::ST_PUN;
            st_next.steal_req = 1'b1;
          end else begin
            st_next.state = crp_pkg::ST_IDLE;
            st_next.busy = 1'b0;
            st_next.complete = (st_reg.extra_left != 2'h1);
          end
        end
      end
      crp_pkg::ST_READ: begin
        // Column latched and checked before transfer; FIFO full stalls reading
        if (column_check_ok_i && fifo_in_ready) begin
          if (st_reg.packed_mode) begin
            if (st_reg.column[0]) begin
              st_next.odd_half = column_data_i[11:4];
            end else begin
              fifo_push = 1'b1;
              fifo_word = {st_reg.odd_half, column_data_i[11:4]};
            end
          end else begin
            fifo_push = 1'b1;
            fifo_word = {4'h0, column_data_i};
          end
          st_next.column = st_reg.column + 7'h01;
          if (st_reg.column == crp_pkg::LAST_COLUMN) begin
            st_next.state = crp_pkg::ST_IDLE;
            st_next.busy = 1'b0;
            st_next.complete = (st_reg.extra_left != 2'h1) || st_reg.last_card;
          end
        end
      end
      crp_pkg::ST_PUN: begin
        if (st_reg.wait_punch) begin
          if (punch_check_ok_i) begin
            st_next.wait_punch = 1'b0;
            st_next.card_punched = 1'b1;
            st_next.column = st_reg.column + 7'h01;
            // Last mark of the word just punched ends the card
            if (st_reg.state == crp_pkg::ST_PUN && st_reg.odd_half[0]) begin
              st_next.state = crp_pkg::ST_IDLE;
              st_next.busy = 1'b0;
              st_next.complete = 1'b1;
            end else begin
              st_next.steal_req = 1'b1;
            end
          end
        end else if (steal_wr_valid_i) begin
          st_next.punch_data = steal_wr_data_i[11:0];
          st_next.odd_half = {7'h00, steal_wr_data_i[crp_pkg::PUNCH_LAST]};
          st_next.punch_step = 1'b1;
          st_next.wait_punch = 1'b1;
          st_next.addr = st_reg.addr + 16'h0001;
        end
      end
      default: begin
        st_next.state = crp_pkg::ST_IDLE;
      end
    endcase
    if (!panel_sync_reg.host_running || panel_sync_reg.runout_key) begin
      st_next.meter = 1'b0;
    end
    st_next.ready = can_ready;
    st_next.status = '0;
    st_next.status[crp_pkg::ST_NOT_READY] = !st_reg.ready || st_reg.busy || st_reg.maint;
    st_next.status[crp_pkg::ST_BUSY] = st_reg.busy;
    st_next.status[crp_pkg::ST_LAST_CARD] = st_reg.last_card;
    st_next.status[crp_pkg::ST_PARITY] = st_reg.parity;
    st_next.status[crp_pkg::ST_PROTECT] = st_reg.protect;
    st_next.status[crp_pkg::ST_ANY_ERROR] = st_reg.parity || st_reg.protect || st_reg.hopper_err;
    st_next.status[crp_pkg::ST_MAINT] = st_reg.maint;
    st_next.status[crp_pkg::ST_HOPPER_ERR] = st_reg.hopper_err;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '{state: crp_pkg::ST_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Read words queue toward the channel; a slow channel stalls the reader
  logic        q_valid;
  logic [15:0] q_data;
  logic [15:0] rd_addr_reg;
  logic        rd_valid_reg;
  logic [15:0] rd_data_reg;
  logic        q_pop;
  assign q_pop = q_valid && (!rd_valid_reg || steal_rd_ready_i);

  crp_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (fifo_push),
    .in_data_i   (fifo_word),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (q_valid),
    .out_data_o  (q_data),
    .out_ready_i (!rd_valid_reg || steal_rd_ready_i)
  );

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
      rd_addr_reg  <= '0;
    end else begin
      if (st_next.accept && cmd_i.code == crp_pkg::CMD_READ) begin
        rd_addr_reg <= st_next.addr;
      end else if (rd_valid_reg && steal_rd_ready_i) begin
        rd_addr_reg <= rd_addr_reg + 16'h0001;
      end
      if (q_pop) begin
        rd_valid_reg <= 1'b1;
        rd_data_reg  <= q_data;
      end else if (steal_rd_ready_i) begin
        rd_valid_reg <= 1'b0;
      end
    end
  end

  assign cmd_accept_o     = st_reg.accept;
  assign cmd_refused_o    = st_reg.refused;
  assign status_word_o    = st_reg.status;
  assign status_valid_o   = st_reg.status_valid;
  assign op_complete_o    = st_reg.complete;
  assign steal_rd_valid_o = rd_valid_reg;
  assign steal_rd_data_o  = rd_data_reg;
  assign steal_rd_addr_o  = rd_addr_reg;
  assign steal_wr_req_o   = st_reg.steal_req;
  assign feed_drive_o     = st_reg.feed_drive;
  assign punch_step_o     = st_reg.punch_step;
  assign punch_data_o     = st_reg.punch_data;
  assign meter_run_o      = st_reg.meter;
  assign ready_o          = st_reg.ready;

  chk_busy_refuse: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cmd_valid_i && st_reg.busy && cmd_i.code != crp_pkg::CMD_SENSE) |=> cmd_refused_o && !cmd_accept_o)
    else $error("command accepted while busy");
  chk_not_ready_busy: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st_reg.busy || st_reg.maint) |=> status_word_o[crp_pkg::ST_NOT_READY])
    else $error("not ready bit missing");
  chk_ready_power: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !panel_sync_reg.power_on |=> !ready_o)
    else $error("ready without power");
  chk_feed_on_read: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cmd_valid_i && !st_reg.busy && st_reg.ready && cmd_i.code == crp_pkg::CMD_READ) |=> feed_drive_o)
    else $error("read did not start feed");
  chk_punch_in_place: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (cmd_valid_i && !st_reg.busy && st_reg.ready && cmd_i.code == crp_pkg::CMD_PUNCH &&
     st_reg.card_at_punch && !st_reg.card_punched) |=> (!feed_drive_o && steal_wr_req_o))
    else $error("punch fed over an unpunched card");
  chk_punch_no_feed: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    punch_step_o |-> !feed_drive_o)
    else $error("feed during punching");
  chk_read_complete: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st_reg.state == crp_pkg::ST_READ && st_reg.column != crp_pkg::LAST_COLUMN) |=> !op_complete_o)
    else $error("early read complete");
  chk_punch_end: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (op_complete_o && $past(st_reg.state) == crp_pkg::ST_PUN) |-> $past(st_reg.odd_half[0]))
    else $error("punch ended without last mark");
  chk_hopper_abort: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (st_reg.state == crp_pkg::ST_FEED && hopper_err_i) |=> ##[0:1] (!punch_step_o && !feed_drive_o))
    else $error("hopper error did not abort");
endmodule

// file: verif/crp_host_model.sv
// Host data channel model: takes read steals, answers punch word requests.
// Assumes the controller holds steal_rd_valid_o until it sees ready.
`timescale 1ns/10ps
module crp_host_model (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  // Read steals
  input  wire logic        rd_valid_i,
  input  wire logic [15:0] rd_data_i,
  input  wire logic [15:0] rd_addr_i,
  output logic             rd_ready_o,
  // Punch steals
  input  wire logic        wr_req_i,
  output logic             wr_valid_o,
  output logic [15:0]      wr_data_o
);
  logic [15:0] mem [0:511];
  logic [15:0] pmem [0:7];
  int          nrd;
  int          nwr;
  int          dly;
  always @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nrd <= 0;
      nwr <= 0;
      dly <= 0;
      rd_ready_o <= 1'b0;
      wr_valid_o <= 1'b0;
      wr_data_o <= 16'h5A5A;
    end else begin
      // Stall every other cycle
      rd_ready_o <= ~rd_ready_o;
      if (rd_valid_i && rd_ready_o) begin
        mem[rd_addr_i[8:0]] <= rd_data_i;
        nrd <= nrd + 1;
      end
      wr_valid_o <= 1'b0;
      // Data not valid outside the answer cycle
      wr_data_o <= ~wr_data_o;
      if (dly == 2) begin
        wr_valid_o <= 1'b1;
        wr_data_o <= pmem[nwr[2:0]];
        nwr <= nwr + 1;
      end
      dly <= wr_req_i ? 1 : (dly == 1 ? 2 : 0);
    end
  end
endmodule

// file: verif/card_read_punch_controller_bench.sv
// Bench for crp_ctrl: command calls, card mechanism responses, expected values.
// Assumes crp_host_model as channel partner; one 100 MHz clock.
`timescale 1ns/10ps
module card_read_punch_controller_bench;
  logic                sys_clk_i = 0, reset_n_i = 0, cmd_valid_i = 0, ipl_i = 0;
  crp_pkg::crp_cmd_t   cmd_i = '0;
  crp_pkg::crp_panel_t panel_i = '{power_on:1, card_at_read:1, hopper_loaded:1, chip_box_ok:1, default:0};
  logic [11:0]         column_data_i = '0, punch_data_o;
  logic                column_check_ok_i = 0, punch_check_ok_i = 0, feed_done_i = 0, hopper_err_i = 0;
  logic                parity_err_i = 0, protect_err_i = 0, cmd_accept_o, cmd_refused_o, status_valid_o;
  logic                op_complete_o, steal_rd_valid_o, steal_rd_ready_i, steal_wr_req_o, steal_wr_valid_i;
  logic                feed_drive_o, punch_step_o, meter_run_o, ready_o, acc, rf;
  logic [15:0]         status_word_o, steal_rd_data_o, steal_rd_addr_o, steal_wr_data_i, sw;
  int                  num_errors = 0, total_checks = 0, opc = 0, fcnt = 0, pcnt = 0, c, k, o;
  logic [11:0]         pq [$];

  crp_ctrl #(.FIFO_DEPTH(16)) u_crp_ctrl (.sys_clk_i, .reset_n_i, .cmd_valid_i, .cmd_i, .ipl_i, .cmd_accept_o,
    .cmd_refused_o, .status_word_o, .status_valid_o, .op_complete_o, .steal_rd_valid_o, .steal_rd_data_o,
    .steal_rd_addr_o, .steal_rd_ready_i, .steal_wr_req_o, .steal_wr_valid_i, .steal_wr_data_i, .parity_err_i,
    .protect_err_i, .panel_i, .column_data_i, .column_check_ok_i, .punch_check_ok_i, .feed_done_i,
    .hopper_err_i, .feed_drive_o, .punch_step_o, .punch_data_o, .meter_run_o, .ready_o);
  crp_host_model u_crp_host_model (.sys_clk_i, .reset_n_i, .rd_valid_i(steal_rd_valid_o),
    .rd_data_i(steal_rd_data_o), .rd_addr_i(steal_rd_addr_o), .rd_ready_o(steal_rd_ready_i),
    .wr_req_i(steal_wr_req_o), .wr_valid_o(steal_wr_valid_i), .wr_data_o(steal_wr_data_i));

  always #5 sys_clk_i = ~sys_clk_i;

  // Mechanism: feed ends 20 cycles into drive, punched column checks 3 after step
  always @(posedge sys_clk_i) begin
    #1;
    feed_done_i = (fcnt == 20);
    fcnt = feed_drive_o ? fcnt + 1 : 0;
    punch_check_ok_i = (pcnt == 3);
    pcnt = punch_step_o ? 1 : ((pcnt > 0 && pcnt < 3) ? pcnt + 1 : 0);
    if (punch_step_o) pq.push_back(punch_data_o);
    if (op_complete_o) opc++;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task cmd(input logic [2:0] code, input logic [15:0] md);
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1;
    cmd_i = '{code, md};
    acc = 0;
    rf = 0;
    repeat (3) begin
      @(posedge sys_clk_i);
      #1;
      cmd_valid_i = 0;
      acc |= cmd_accept_o;
      rf |= cmd_refused_o;
      if (status_valid_o) sw = status_word_o;
    end
  endtask

  task rd(input logic [15:0] md, input logic ip);
    #1 ipl_i = ip;
    k = u_crp_host_model.nrd;
    o = opc;
    cmd(crp_pkg::CMD_READ, md);
    chk(16'(acc), 16'h0001);
    repeat (30) @(posedge sys_clk_i);
    for (c = 1; c <= 80; c++) begin
      #1;
      column_data_i = {c[7:0], 4'hA};
      column_check_ok_i = 1;
      parity_err_i = (c == 40);
      @(posedge sys_clk_i);
      #1;
      column_check_ok_i = 0;
      parity_err_i = 0;
      repeat (3) @(posedge sys_clk_i);
    end
    repeat (60) @(posedge sys_clk_i);
    #1 ipl_i = 0;
    chk(16'(opc - o), 16'h0001);
    chk(16'(ready_o), 16'h0001);
  endtask

  task results;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    num_errors++;
    results;
  end

  initial begin
    panel_i.host_running = 1;
    repeat (5) @(posedge sys_clk_i);
    #1 reset_n_i = 1;
    repeat (6) @(posedge sys_clk_i);
    chk(16'(ready_o), 16'h0001);
    cmd(crp_pkg::CMD_SENSE, 16'h8000);
    chk(16'(sw[1:0]), 16'h0000);
    k = u_crp_host_model.nrd;
    cmd(crp_pkg::CMD_CONTROL, 16'h4000);
    chk(16'(acc), 16'h0001);
    cmd(crp_pkg::CMD_CONTROL, 16'h4000);
    chk(16'(rf), 16'h0001);
    cmd(crp_pkg::CMD_SENSE, 16'h0000);
    chk(16'(sw[1:0]), 16'h0003);
    repeat (40) @(posedge sys_clk_i);
    chk(16'(u_crp_host_model.nrd - k), 16'h0000);
    rd(16'h8000, 1);
    chk(16'(u_crp_host_model.nrd - k), 16'h0028);
    for (c = 0; c < 40; c++) chk(u_crp_host_model.mem[c], {8'(2 * c + 1), 8'(2 * c + 2)});
    cmd(crp_pkg::CMD_SENSE, 16'h8000);
    chk(16'(sw[crp_pkg::ST_PARITY]), 16'h0001);
    cmd(crp_pkg::CMD_SENSE, 16'h0000);
    chk(16'(sw[crp_pkg::ST_PARITY]), 16'h0000);
    rd(16'h0100, 0);
    chk(16'(u_crp_host_model.nrd - k), 16'h0050);
    for (c = 1; c <= 80; c++) chk(u_crp_host_model.mem[255 + c], {4'h0, c[7:0], 4'hA});
    u_crp_host_model.pmem[0] = 16'h0123;
    u_crp_host_model.pmem[1] = 16'h0456;
    u_crp_host_model.pmem[2] = 16'h1789;
    o = opc;
    cmd(crp_pkg::CMD_PUNCH, 16'h0200);
    chk(16'(acc), 16'h0001);
    repeat (150) @(posedge sys_clk_i);
    chk(16'(pq.size()), 16'h0003);
    for (c = 0; c < 3; c++) chk(16'(pq[c]), 16'(u_crp_host_model.pmem[c][11:0]));
    chk(16'(opc - o), 16'h0001);
    chk(16'(meter_run_o), 16'h0001);
    cmd(crp_pkg::CMD_CONTROL, 16'h0000);
    chk(16'(meter_run_o), 16'h0000);
    cmd(crp_pkg::CMD_MAINT, 16'h8000);
    cmd(crp_pkg::CMD_SENSE, 16'h0000);
    chk(16'(sw[crp_pkg::ST_MAINT]), 16'h0001);
    chk(16'(sw[crp_pkg::ST_NOT_READY]), 16'h0001);
    cmd(crp_pkg::CMD_MAINT, 16'h0000);
    cmd(crp_pkg::CMD_SENSE, 16'h0000);
    chk(16'(sw[crp_pkg::ST_NOT_READY]), 16'h0000);
    #1 panel_i.check_light = 1;
    repeat (6) @(posedge sys_clk_i);
    chk(16'(ready_o), 16'h0000);
    cmd(crp_pkg::CMD_CONTROL, 16'h4000);
    chk(16'(rf), 16'h0001);
    cmd(crp_pkg::CMD_SENSE, 16'h0000);
    chk(16'(sw[crp_pkg::ST_NOT_READY]), 16'h0001);
    results;
  end
endmodule
